// File: rtl/sspi_defines.vh
`ifndef SSPI_DEFINES_VH
`define SSPI_DEFINES_VH

// Mode field encodings
`define SSPI_MODE_M_DIV4      4'h0
`define SSPI_MODE_M_DIV16     4'h1
`define SSPI_MODE_M_DIV64     4'h2
`define SSPI_MODE_M_TMR2      4'h3
`define SSPI_MODE_S_SS_ON     4'h4
`define SSPI_MODE_S_SS_OFF    4'h5

// Rate select, the low two mode bits in master modes
`define SSPI_RATE_DIV4        2'h0
`define SSPI_RATE_DIV16       2'h1
`define SSPI_RATE_DIV64       2'h2
`define SSPI_RATE_TMR2        2'h3

// Half bit periods in clock cycles
`define SSPI_HALF_DIV4        6'h02
`define SSPI_HALF_DIV16       6'h08
`define SSPI_HALF_DIV64       6'h20
`define SSPI_DIV_ONE          6'h01
`define SSPI_DIV_ZERO         6'h00

// Byte framing
`define SSPI_MSB              7
`define SSPI_LAST_BIT         4'h7
`define SSPI_LAST_HALF        5'h0f
`define SSPI_BYTE_ZERO        8'h00
`define SSPI_HALF_ZERO        5'h00
`define SSPI_HALF_ONE         5'h01
`define SSPI_BIT_ZERO         4'h0
`define SSPI_BIT_ONE          4'h1

`endif

// File: rtl/sspi_sync3.v
`timescale 1ns/1ps
`include "sspi_defines.vh"

module sspi_sync3
(
  input  wire clock,
  input  wire rstn,
  input  wire async_in,
  output wire level
);

  reg stage1_ff;
  reg stage2_ff;
  reg stage3_ff;
  reg level_ff;

  // Level moves only once the last two stages agree
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
      stage3_ff <= 1'b0;
      level_ff  <= 1'b0;
    end
    else
    begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      if (stage2_ff == stage3_ff)
        level_ff <= stage3_ff;
    end
  end

  assign level = level_ff;

endmodule // sspi_sync3

// File: rtl/sspi_clkdiv.v
`timescale 1ns/1ps
`include "sspi_defines.vh"

module sspi_clkdiv
(
  input  wire       clock,
  input  wire       rstn,
  input  wire       run,
  input  wire [1:0] rate_sel,
  input  wire       tmr2_tick,
  output wire       half_tick
);

  reg  [5:0] cnt_ff;
  reg  [5:0] nxt_cnt;
  reg  [5:0] half_len;
  reg        tick;

  always @*
  begin
    case (rate_sel)
      `SSPI_RATE_DIV4:  half_len = `SSPI_HALF_DIV4;
      `SSPI_RATE_DIV16: half_len = `SSPI_HALF_DIV16;
      `SSPI_RATE_DIV64: half_len = `SSPI_HALF_DIV64;
      default:          half_len = `SSPI_DIV_ONE;
    endcase
    tick    = 1'b0;
    nxt_cnt = cnt_ff;
    if (!run)
      nxt_cnt = `SSPI_DIV_ZERO;
    else if (rate_sel == `SSPI_RATE_TMR2)
      tick = tmr2_tick; // each timer tick is half a bit
    else if (cnt_ff == half_len - `SSPI_DIV_ONE)
    begin
      tick    = 1'b1;
      nxt_cnt = `SSPI_DIV_ZERO;
    end
    else
      nxt_cnt = cnt_ff + `SSPI_DIV_ONE;
  end

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cnt_ff <= `SSPI_DIV_ZERO;
    else
      cnt_ff <= nxt_cnt;
  end

  assign half_tick = tick;

endmodule // sspi_clkdiv

// File: rtl/sspi_core.v
// Summary of operation
// - Eight bits sent and received together
// - Shift register moves MSB first
// - Full byte goes to buffer, flags set
// - Next byte may arrive before buffer read
// - Write while busy dropped, collision flag set
// - Reading buffer clears buffer full flag
// - Shift register reached only through buffer
// - Enable bit hands pins to port
// - Shift on one edge, sample opposite
// - Master starts transfer on buffer write
// - Master with clock input keeps receiving
// - Slave shifts on external clock, flags
// - Polarity bit sets clock idle level
// - Master rate: div 4, 16, 64, timer
// - Slave works in sleep, wakes device
// - Select control only mode 4, input
// - Select high stops driving data output
// - Select high resets transfer logic
// - Data output as input never transmits
`timescale 1ns/1ps
`include "sspi_defines.vh"

module sspi_core
(
  input  wire       clock,
  input  wire       rstn,
  input  wire [7:0] buf_wdata,
  input  wire       buf_wr,
  input  wire       buf_rd,
  output wire [7:0] buf_rdata,
  input  wire       port_enable_bit,
  input  wire       clock_idle_polarity,
  input  wire       clock_edge_sel,
  input  wire [3:0] port_mode_field,
  input  wire       write_collision_flag_clear,
  input  wire       irq_clear,
  output wire       buffer_full_flag,
  output wire       port_irq_flag,
  output wire       write_collision_flag,
  output wire       wake_pulse,
  input  wire       sleep_mode,
  input  wire       timer2_tick,
  input  wire       data_out_is_input,
  input  wire       clock_is_input,
  input  wire       select_is_input,
  input  wire       data_in_pin,
  input  wire       serial_clock_pin_in,
  output wire       serial_clock_pin_out,
  output wire       serial_clock_pin_oe,
  output wire       data_out_pin_out,
  output wire       data_out_pin_oe,
  input  wire       slave_select_pin
);

  reg  [7:0] shift_reg_ff;
  reg  [7:0] nxt_shift_reg;
  reg  [7:0] xfer_buffer_ff;
  reg  [7:0] nxt_xfer_buffer;
  reg        bf_ff;
  reg        nxt_bf;
  reg        irq_ff;
  reg        nxt_irq;
  reg        write_collision_flag_ff;
  reg        nxt_write_collision_flag;
  reg        wake_ff;
  reg        nxt_wake;
  reg        m_active_ff;
  reg        nxt_m_active;
  reg  [4:0] half_cnt_ff;
  reg  [4:0] nxt_half_cnt;
  reg  [3:0] bit_cnt_ff;
  reg  [3:0] nxt_bit_cnt;
  reg        sck_ff;
  reg        nxt_sck;
  reg        sdo_ff;
  reg        nxt_sdo;
  reg        sck_prev_ff;

  wire       din_s;
  wire       sck_s;
  wire       ss_s;
  wire       half_tick;

  wire       is_master;
  wire       is_slave;
  wire       ss_ctrl;
  wire       ss_block;
  wire       busy;
  wire       s_lead;
  wire       s_trail;
  wire       m_lead;
  wire       m_trail;
  wire       in_edge;
  wire       out_edge;
  wire       complete;
  wire       start_wr;
  wire       start_mon;

  // Pins from outside the clock domain
  sspi_sync3 u_sync_din
  (
    .clock    (clock),
    .rstn     (rstn),
    .async_in (data_in_pin),
    .level    (din_s)
  );

  sspi_sync3 u_sync_sck
  (
    .clock    (clock),
    .rstn     (rstn),
    .async_in (serial_clock_pin_in),
    .level    (sck_s)
  );

  sspi_sync3 u_sync_ss
  (
    .clock    (clock),
    .rstn     (rstn),
    .async_in (slave_select_pin),
    .level    (ss_s)
  );

  // Mode decode; the remaining codes leave the port idle
  assign is_master = port_enable_bit &&
                     (port_mode_field <= `SSPI_MODE_M_TMR2);
  assign is_slave  = port_enable_bit &&
                     ((port_mode_field == `SSPI_MODE_S_SS_ON) ||
                      (port_mode_field == `SSPI_MODE_S_SS_OFF));

  // Select control needs the select pin as an input
  assign ss_ctrl  = is_slave && select_is_input &&
                    (port_mode_field == `SSPI_MODE_S_SS_ON);
  assign ss_block = ss_ctrl && ss_s;

  sspi_clkdiv u_div
  (
    .clock     (clock),
    .rstn      (rstn),
    .run       (m_active_ff),
    .rate_sel  (port_mode_field[1:0]),
    .tmr2_tick (timer2_tick),
    .half_tick (half_tick)
  );

  // Even half periods leave idle level, odd ones return to it
  // Limitation: at the fastest rate input sync delay exceeds half a bit
  assign m_lead  = m_active_ff && half_tick && !half_cnt_ff[0];
  assign m_trail = m_active_ff && half_tick && half_cnt_ff[0];

  // One rule for both slave edges keeps them consistent
  function slave_edge;
    input prev_lvl;
    input now_lvl;
    input idle_lvl;
    input leading;
    begin
      if (leading)
        slave_edge = (prev_lvl == idle_lvl) && (now_lvl != idle_lvl);
      else
        slave_edge = (prev_lvl != idle_lvl) && (now_lvl == idle_lvl);
    end
  endfunction

  // Bit counter wraps after the last bit of a byte
  function [3:0] next_bit;
    input [3:0] cnt;
    begin
      if (cnt == `SSPI_LAST_BIT)
        next_bit = `SSPI_BIT_ZERO;
      else
        next_bit = cnt + `SSPI_BIT_ONE;
    end
  endfunction

  // Slave edges from the synchronised clock, relative to idle level
  assign s_lead  = is_slave && !ss_block &&
                   slave_edge(sck_prev_ff, sck_s, clock_idle_polarity,
                              1'b1);
  assign s_trail = is_slave && !ss_block &&
                   slave_edge(sck_prev_ff, sck_s, clock_idle_polarity,
                              1'b0);

  // Edge select picks which edge samples and which shifts out
  assign in_edge  = clock_edge_sel ? (m_trail | s_trail)
                                   : (m_lead | s_lead);
  assign out_edge = clock_edge_sel ? (m_lead | s_lead)
                                   : (m_trail | s_trail);

  assign complete = (m_active_ff && half_tick &&
                     (half_cnt_ff == `SSPI_LAST_HALF)) ||
                    (is_slave && in_edge &&
                     (bit_cnt_ff == `SSPI_LAST_BIT));

  assign busy = is_master ? m_active_ff
                          : (bit_cnt_ff != `SSPI_BIT_ZERO);

  assign start_wr  = buf_wr && !busy && (is_master || is_slave);
  // Clock pin as input in master mode: free running receiver
  assign start_mon = is_master && clock_is_input &&
                     !m_active_ff && !start_wr;

  always @*
  begin
    nxt_shift_reg   = shift_reg_ff;
    nxt_xfer_buffer = xfer_buffer_ff;
    nxt_bf          = bf_ff;
    nxt_irq         = irq_ff;
    nxt_write_collision_flag        = write_collision_flag_ff;
    nxt_wake        = 1'b0;
    nxt_m_active    = m_active_ff;
    nxt_half_cnt    = half_cnt_ff;
    nxt_bit_cnt     = bit_cnt_ff;
    nxt_sck         = sck_ff;
    nxt_sdo         = sdo_ff;

    // Clears first so a same-cycle set below wins
    if (buf_rd)
      nxt_bf = 1'b0;
    if (irq_clear)
      nxt_irq = 1'b0;
    if (write_collision_flag_clear)
      nxt_write_collision_flag = 1'b0;

    if (!is_master && !is_slave)
    begin
      // Disabled or reconfiguring: transfer logic back to idle
      nxt_m_active = 1'b0;
      nxt_half_cnt = `SSPI_HALF_ZERO;
      nxt_bit_cnt  = `SSPI_BIT_ZERO;
      nxt_sck      = clock_idle_polarity;
      if (buf_wr)
        nxt_xfer_buffer = buf_wdata;
    end
    else
    begin
      if (!m_active_ff)
        nxt_sck = clock_idle_polarity;

      if (ss_block)
        nxt_bit_cnt = `SSPI_BIT_ZERO;

      if (buf_wr && busy)
        nxt_write_collision_flag = 1'b1;
      else if (start_wr)
      begin
        // Shift register is loaded only through the buffer
        nxt_shift_reg   = buf_wdata;
        nxt_xfer_buffer = buf_wdata;
        nxt_sdo         = buf_wdata[`SSPI_MSB];
        if (is_master)
        begin
          nxt_m_active = 1'b1;
          nxt_half_cnt = `SSPI_HALF_ZERO;
        end
      end
      else if (start_mon)
      begin
        nxt_m_active = 1'b1;
        nxt_half_cnt = `SSPI_HALF_ZERO;
      end

      if (m_active_ff && half_tick)
      begin
        nxt_sck      = ~sck_ff;
        nxt_half_cnt = half_cnt_ff + `SSPI_HALF_ONE;
        if (half_cnt_ff == `SSPI_LAST_HALF)
          nxt_m_active = start_mon;
      end

      // Sampling keeps the new bit at the bottom, MSB leaves first
      if (in_edge)
      begin
        nxt_shift_reg = {shift_reg_ff[`SSPI_MSB-1:0], din_s};
        if (is_slave)
          nxt_bit_cnt = next_bit(bit_cnt_ff);
      end
      if (out_edge)
        nxt_sdo = shift_reg_ff[`SSPI_MSB];

      if (complete)
      begin
        // Buffer takes the byte; the shifter is free again at once
        nxt_xfer_buffer = nxt_shift_reg;
        nxt_bf          = 1'b1;
        nxt_irq         = 1'b1;
        nxt_wake        = sleep_mode && is_slave;
      end
    end
  end

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      shift_reg_ff   <= `SSPI_BYTE_ZERO;
      xfer_buffer_ff <= `SSPI_BYTE_ZERO;
      bf_ff          <= 1'b0;
      irq_ff         <= 1'b0;
      write_collision_flag_ff        <= 1'b0;
      wake_ff        <= 1'b0;
      m_active_ff    <= 1'b0;
      half_cnt_ff    <= `SSPI_HALF_ZERO;
      bit_cnt_ff     <= `SSPI_BIT_ZERO;
      sck_ff         <= 1'b0;
      sdo_ff         <= 1'b0;
      sck_prev_ff    <= 1'b0;
    end
    else
    begin
      shift_reg_ff   <= nxt_shift_reg;
      xfer_buffer_ff <= nxt_xfer_buffer;
      bf_ff          <= nxt_bf;
      irq_ff         <= nxt_irq;
      write_collision_flag_ff        <= nxt_write_collision_flag;
      wake_ff        <= nxt_wake;
      m_active_ff    <= nxt_m_active;
      half_cnt_ff    <= nxt_half_cnt;
      bit_cnt_ff     <= nxt_bit_cnt;
      sck_ff         <= nxt_sck;
      sdo_ff         <= nxt_sdo;
      sck_prev_ff    <= sck_s;
    end
  end

  assign buf_rdata            = xfer_buffer_ff;
  assign buffer_full_flag     = bf_ff;
  assign port_irq_flag        = irq_ff;
  assign write_collision_flag = write_collision_flag_ff;
  assign wake_pulse           = wake_ff;

  // Clock driven only by an enabled master with the pin as output
  assign serial_clock_pin_out = sck_ff;
  assign serial_clock_pin_oe  = is_master && !clock_is_input;

  // Data output floats four clocks after select rises, once synchronised, even mid-byte
  assign data_out_pin_out = sdo_ff;
  assign data_out_pin_oe  = (is_master || (is_slave && !ss_block)) &&
                            !data_out_is_input;

endmodule // sspi_core

// File: verification/sspi_core_checker.sv
`timescale 1ns/1ps
module sspi_core_checker (
  input       clock,
  input       rstn,
  input       buf_wr,
  input       buf_rd,
  input       write_collision_flag_clear,
  input       port_enable_bit,
  input       clock_idle_polarity,
  input [3:0] port_mode_field,
  input       clock_is_input,
  input       data_out_is_input,
  input       select_is_input,
  input       slave_select_pin,
  input       buffer_full_flag,
  input       port_irq_flag,
  input       write_collision_flag,
  input       wake_pulse,
  input       serial_clock_pin_out,
  input       serial_clock_pin_oe,
  input       data_out_pin_oe
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  wire master = port_enable_bit && port_mode_field < 4'h4 && !clock_is_input;
  a_off_no_drive:
    assert property (!port_enable_bit |-> !serial_clock_pin_oe
      && !data_out_pin_oe) else $error("pins driven while disabled");
  a_din_no_drive:
    assert property (data_out_is_input |-> !data_out_pin_oe)
      else $error("data out driven while input");
  a_slave_clk_in:
    assert property (port_enable_bit && port_mode_field[3:1] == 3'h2
      |-> !serial_clock_pin_oe) else $error("slave drives clock");
  a_master_clk_out:
    assert property (master |-> serial_clock_pin_oe)
      else $error("master not driving clock");
  a_full_with_irq:
    assert property ($rose(buffer_full_flag) |-> port_irq_flag)
      else $error("full flag without irq flag");
  a_read_clears_full:
    assert property (buf_rd && !port_irq_flag |=> !buffer_full_flag
      || port_irq_flag) else $error("read left full flag");
  a_write_collision_flag_sticky:
    assert property (write_collision_flag && !write_collision_flag_clear
      |=> write_collision_flag) else $error("collision flag lost");
  a_write_collision_flag_clear:
    assert property (write_collision_flag_clear && !buf_wr |=> !write_collision_flag)
      else $error("collision flag not cleared");
  a_div16_half_rate:
    assert property (master && port_mode_field == 4'h1
      && $changed(serial_clock_pin_out) && $stable(clock_idle_polarity)
      |=> $stable(serial_clock_pin_out)[*7]) else $error("div16 rate");
  a_idle_after_byte:
    assert property ($rose(port_irq_flag) && master
      |-> serial_clock_pin_out == clock_idle_polarity)
      else $error("clock not idle after byte");
  a_wake_one_cycle:
    assert property (wake_pulse |-> port_irq_flag ##1 !wake_pulse)
      else $error("wake pulse wrong");
  a_select_float:
    assert property ((port_enable_bit && port_mode_field == 4'h4
      && select_is_input && slave_select_pin)[*5] |-> !data_out_pin_oe)
      else $error("data out driven while deselected");
  c_collision: cover property ($rose(write_collision_flag));
  c_wake: cover property (wake_pulse);
  c_full: cover property ($rose(buffer_full_flag));
endmodule // sspi_core_checker
bind sspi_core sspi_core_checker sspi_core_checker_i (.clock, .rstn,
  .buf_wr, .buf_rd, .write_collision_flag_clear, .port_enable_bit, .clock_idle_polarity,
  .port_mode_field, .clock_is_input, .data_out_is_input, .select_is_input,
  .slave_select_pin, .buffer_full_flag, .port_irq_flag,
  .write_collision_flag, .wake_pulse, .serial_clock_pin_out,
  .serial_clock_pin_oe, .data_out_pin_oe);

// File: verification/sspi_far_end.sv
`timescale 1ns/1ps
module sspi_far_end (
  input        sck_in,
  input        cpol,
  input        cke,
  input        sdo,
  input  [7:0] tx,
  input        load,
  output       din,
  output logic sck_m,
  output logic [7:0] rx
);
  logic [7:0] sr_ff = 8'h00;
  logic       out_ff = 1'b0;
  wire        ck = sck_in ^ cpol ^ cke;
  initial sck_m = 1'b0;
  initial rx = 8'h00;
  assign din = cke ? out_ff : sr_ff[7];
  always @(posedge load) sr_ff = tx;
  always @(posedge ck) rx <= {rx[6:0], sdo};
  // Refill with changing bits so a stale level never looks valid
  always @(negedge ck)
  begin
    out_ff <= sr_ff[7]; // leading edge drives out when cke set
    sr_ff <= {sr_ff[6:0], ~sr_ff[7]};
  end
  task automatic xfer(input int halves, input int half_ns);
    repeat (halves) #(half_ns) sck_m = ~sck_m;
  endtask
endmodule // sspi_far_end

// File: verification/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
  n_errors++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module testbench;
  logic       clock = 1'b0, rstn = 1'b0, buf_wr = 1'b0, buf_rd = 1'b0;
  logic       port_enable_bit = 1'b0, clock_idle_polarity = 1'b0;
  logic       write_collision_flag_clear = 1'b0, irq_clear = 1'b0, sleep_mode = 1'b0;
  logic       clock_edge_sel = 1'b0;
  logic       clock_is_input = 1'b0, data_out_is_input = 1'b0;
  logic       select_is_input = 1'b1;
  logic       timer2_tick = 1'b0, slave_select_pin = 1'b1, far_load = 1'b0;
  logic [3:0] port_mode_field = 4'h0;
  logic [7:0] buf_wdata = 8'h00, far_tx = 8'h00;
  logic [2:0] t2_cnt = 3'h0;
  wire  [7:0] buf_rdata, far_rx;
  wire        buffer_full_flag, port_irq_flag, write_collision_flag;
  wire        wake_pulse, serial_clock_pin_out, serial_clock_pin_oe;
  wire        data_out_pin_out, data_out_pin_oe, data_in_pin, sck_m;
  wire        serial_clock_pin_in = sck_m;
  wire        far_sck = serial_clock_pin_oe ? serial_clock_pin_out : sck_m;
  wire        far_sdo = data_out_pin_oe ? data_out_pin_out : ~data_out_pin_out;
  int         n_errors = 0, total_checks = 0, n_wake = 0;
  always #4 clock = ~clock;
  always @(posedge clock)
  begin
    t2_cnt <= (t2_cnt == 3'h4) ? 3'h0 : t2_cnt + 3'h1;
    timer2_tick <= (t2_cnt == 3'h4);
    if (wake_pulse === 1'b1) n_wake++;
  end
  sspi_core sspi_core_i (.clock, .rstn, .buf_wdata, .buf_wr, .buf_rd,
    .buf_rdata, .port_enable_bit, .clock_idle_polarity, .clock_edge_sel,
    .port_mode_field, .write_collision_flag_clear, .irq_clear, .buffer_full_flag,
    .port_irq_flag, .write_collision_flag, .wake_pulse, .sleep_mode,
    .timer2_tick, .data_out_is_input, .clock_is_input, .select_is_input,
    .data_in_pin, .serial_clock_pin_in, .serial_clock_pin_out,
    .serial_clock_pin_oe, .data_out_pin_out, .data_out_pin_oe,
    .slave_select_pin);
  sspi_far_end sspi_far_end_i (.sck_in(far_sck), .cpol(clock_idle_polarity),
    .cke(clock_edge_sel), .sdo(far_sdo), .tx(far_tx), .load(far_load),
    .din(data_in_pin), .sck_m,
    .rx(far_rx));
  task automatic tick;
    @(posedge clock);
    #1;
  endtask
  task automatic pulse_wr(input logic [7:0] d);
    @(posedge clock);
    buf_wdata <= d;
    buf_wr <= 1'b1;
    @(posedge clock);
    buf_wr <= 1'b0;
    #1;
  endtask
  task automatic pulse3(input logic r, c, q);
    @(posedge clock);
    {buf_rd, write_collision_flag_clear, irq_clear} <= {r, c, q};
    @(posedge clock);
    {buf_rd, write_collision_flag_clear, irq_clear} <= 3'h0;
    #1;
  endtask
  task automatic far(input logic [7:0] t);
    far_tx = t;
    #1 far_load = 1'b1;
    #1 far_load = 1'b0;
  endtask
  task automatic cfg(input logic [3:0] m, input logic pol);
    @(posedge clock);
    port_enable_bit <= 1'b0;
    @(posedge clock);
    port_mode_field <= m;
    clock_idle_polarity <= pol;
    @(posedge clock);
    port_enable_bit <= 1'b1;
    repeat (6) tick;
    pulse3(1'b1, 1'b1, 1'b1);
  endtask
  task automatic wait_irq;
    int k = 0;
    while (port_irq_flag !== 1'b1 && k < 2000)
    begin
      tick;
      k++;
    end
    `CHK("irq_set", 1'b1, port_irq_flag)
  endtask
  task automatic wait_tog(output int k);
    logic v = serial_clock_pin_out;
    k = 0;
    while (serial_clock_pin_out === v && k < 400)
    begin
      tick;
      k++;
    end
  endtask
  task automatic t_master(input logic [3:0] m, input logic pol, input int h);
    int k;
    cfg(m, pol);
    far(8'h96);
    pulse_wr(8'ha3);
    wait_tog(k);
    wait_tog(k);
    `CHK("half_period", h, k)
    pulse_wr(8'h3c);
    `CHK("write_collision_flag_set", 1'b1, write_collision_flag)
    wait_irq;
    `CHK("far_rx", 8'ha3, far_rx)
    if (m != 4'h0) `CHK("buf_rdata", 8'h96, buf_rdata)
    `CHK("idle_clk", pol, serial_clock_pin_out)
    `CHK("bf_set", 1'b1, buffer_full_flag)
    pulse3(1'b0, 1'b0, 1'b1);
    pulse3(1'b1, 1'b0, 1'b0);
    `CHK("bf_read", 1'b0, buffer_full_flag)
    `CHK("write_collision_flag_hold", 1'b1, write_collision_flag)
    pulse3(1'b0, 1'b1, 1'b0);
    `CHK("write_collision_flag_clr", 1'b0, write_collision_flag)
  endtask
  task automatic t_mon;
    @(posedge clock);
    clock_is_input <= 1'b1;
    data_out_is_input <= 1'b1;
    far(8'hff);
    cfg(4'h1, 1'b0);
    wait_irq;
    `CHK("mon_byte", 8'hff, buf_rdata)
    `CHK("do_input", 1'b0, data_out_pin_oe)
    pulse3(1'b0, 1'b0, 1'b1);
    wait_irq;
    `CHK("unread_full", 1'b1, buffer_full_flag)
    @(posedge clock);
    data_out_is_input <= 1'b0;
  endtask
  task automatic slv(input logic [7:0] d, t, input int halves);
    far(t);
    pulse_wr(d);
    repeat (6) tick;
    sspi_far_end_i.xfer(halves, 80);
    repeat (12) tick;
  endtask
  task automatic t_slave(input logic [3:0] m, input logic ss, s,
                         input logic [7:0] d, t);
    int w = n_wake;
    @(posedge clock);
    slave_select_pin <= ss;
    sleep_mode <= s;
    cfg(m, 1'b0);
    slv(d, t, 16);
    `CHK("slv_rx", t, buf_rdata)
    `CHK("far_rx", d, far_rx)
    `CHK("slv_irq", 1'b1, port_irq_flag)
    `CHK("wakes", w + s, n_wake)
    @(posedge clock);
    sleep_mode <= 1'b0;
  endtask
  task automatic t_abort;
    @(posedge clock);
    slave_select_pin <= 1'b0;
    cfg(4'h4, 1'b0);
    slv(8'h11, 8'hc5, 8);
    @(posedge clock);
    slave_select_pin <= 1'b1;
    repeat (6) tick;
    `CHK("oe_float", 1'b0, data_out_pin_oe)
    `CHK("no_irq", 1'b0, port_irq_flag)
    @(posedge clock);
    slave_select_pin <= 1'b0;
    slv(8'h22, 8'h6e, 16);
    `CHK("abort_rx", 8'h6e, buf_rdata)
    `CHK("abort_far", 8'h22, far_rx)
  endtask
  task automatic t_cke;
    @(posedge clock);
    clock_edge_sel <= 1'b1;
    t_slave(4'h4, 1'b0, 1'b0, 8'h5a, 8'hc3);
    @(posedge clock);
    clock_edge_sel <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) tick;
    `CHK("rst_oe", 1'b0, data_out_pin_oe)
    t_master(4'h0, 1'b0, 2);
    t_master(4'h1, 1'b1, 8);
    t_master(4'h2, 1'b0, 32);
    t_master(4'h3, 1'b0, 5);
    t_mon;
    t_slave(4'h5, 1'b1, 1'b1, 8'h4b, 8'hd2);
    t_slave(4'h4, 1'b0, 1'b0, 8'h81, 8'h7e);
    t_abort;
    t_cke;
    print_verdict;
  end
  initial
  begin
    #400000;
    n_errors++;
    print_verdict;
  end
endmodule // testbench
